/* design/sbdz_pkg.sv */
package sbdz_pkg;

  // ---------------------------------------------------------------------
  // widths and constants
  // ---------------------------------------------------------------------
  localparam int unsigned   DATA_W      = 8;
  localparam logic [7:0]    BYTE_ZERO   = 8'h00;
  localparam logic [7:0]    BYTE_ONE    = 8'h01;
  localparam logic [7:0]    DATA_RST    = 8'h00;
  localparam logic          FLAG_RST    = 1'b0;
  // dummy cycles added when the decrement result skips the next opcode
  localparam int unsigned   SKIP_DUMMY_CYCLES = 1;

  // ---------------------------------------------------------------------
  // sequencing states
  // ---------------------------------------------------------------------
  typedef enum logic {
    st_idle,
    st_dummy
  } exec_state_type;

endpackage

/* design/sub_borrow_alu.sv */
// 8-bit subtract with inverted carry as borrow-in; flags use the
// no-borrow convention, so carry and half carry read 1 when nothing borrows
module sub_borrow_alu
(
  // operands
  input  wire logic [7:0] minuend,
  input  wire logic [7:0] subtrahend,
  input  wire logic       carry_in,
  // result
  output logic      [7:0] difference,
  output logic            carry_out,
  output logic            half_carry_out,
  output logic            overflow_out,
  output logic            sign_out
);

  logic [8:0] wide;
  logic [4:0] low;

  always_comb
  begin
    wide = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, ~carry_in};
    low  = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]}
           - {4'h0, ~carry_in};
    difference     = wide[7:0];
    carry_out      = ~wide[8];
    half_carry_out = ~low[4];
    // signed overflow: operand signs differ and result sign left minuend's
    overflow_out   = (minuend[7] ^ subtrahend[7])
                     & (minuend[7] ^ wide[7]);
    // true sign of the signed difference, corrected for overflow
    sign_out       = wide[7] ^ overflow_out;
  end

endmodule // sub_borrow_alu

/* design/sub_borrow_decrement_skip_exec.sv */
// Operation
// - subtract writes acc minus mem minus not-carry
// - negative difference clears carry flag
// - zero or positive difference sets carry
// - subtract updates all six arithmetic flags
// - decrement writes addressed byte minus one back
// - zero decrement result skips following instruction
// - skip inserts one dummy cycle, two total
// - nonzero result continues without skip cycle
module sub_borrow_decrement_skip_exec
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       arst_n,
  // decoded instruction
  input  wire logic       op_valid,
  input  wire logic       op_subtract_borrow_to_memory,
  input  wire logic       op_decrement_skip_if_zero,
  // operands
  input  wire logic [7:0] acc_in,
  input  wire logic [7:0] mem_rdata,
  input  wire logic       carry_in,
  input  wire logic       chained_zero_in,
  // data memory write
  output logic            mem_we,
  output logic      [7:0] mem_wdata,
  // flag writeback
  output logic            flag_we,
  output logic            carry_flag,
  output logic            zero_flag,
  output logic            half_carry_flag,
  output logic            arith_range_exceeded_flag,
  output logic            signed_borrow_result_flag,
  output logic            chained_zero_flag,
  // sequencing
  output logic            skip_next,
  output logic            busy
);

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  typedef struct packed {
    sbdz_pkg::exec_state_type st;
    logic                     mem_we;
    logic [7:0]               wdata;
    logic                     flag_we;
    logic                     c;
    logic                     z;
    logic                     half_c;
    logic                     range_exc;
    logic                     sgn_b;
    logic                     chain_z;
    logic                     skip;
    logic                     busy;
  } exec_regs_type;

  exec_regs_type s_r;
  exec_regs_type s_nxt;

  logic [7:0] diff;
  logic       alu_c;
  logic       alu_hc;
  logic       alu_range;
  logic       alu_sign;
  logic [7:0] dec;
  logic       take;

  // ---------------------------------------------------------------------
  // datapath
  // ---------------------------------------------------------------------
  sub_borrow_alu u_alu
  (
    .minuend        (acc_in),
    .subtrahend     (mem_rdata),
    .carry_in       (carry_in),
    .difference     (diff),
    .carry_out      (alu_c),
    .half_carry_out (alu_hc),
    .overflow_out   (alu_range),
    .sign_out       (alu_sign)
  );

  // plain 8-bit subtract wraps 00 to ff, which is nonzero so no skip
  assign dec  = mem_rdata - sbdz_pkg::BYTE_ONE;
  // the dummy cycle owns the pipe; an opcode offered during it is ignored
  assign take = op_valid && (s_r.st == sbdz_pkg::st_idle);

  // ---------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------
  always_comb
  begin
    s_nxt         = s_r;
    s_nxt.mem_we  = 1'b0;
    s_nxt.flag_we = 1'b0;
    s_nxt.skip    = 1'b0;
    s_nxt.busy    = 1'b0;
    s_nxt.st      = sbdz_pkg::st_idle;
    unique case (s_r.st)
      sbdz_pkg::st_idle:
      begin
        if (take && op_subtract_borrow_to_memory)
        begin
          s_nxt.mem_we    = 1'b1;
          s_nxt.wdata     = diff;
          s_nxt.flag_we   = 1'b1;
          s_nxt.c         = alu_c;
          s_nxt.z         = (diff == sbdz_pkg::BYTE_ZERO);
          s_nxt.half_c    = alu_hc;
          s_nxt.range_exc = alu_range;
          s_nxt.sgn_b     = alu_sign;
          // chained zero only stays set while every byte of a chain is zero
          s_nxt.chain_z   = chained_zero_in
                            && (diff == sbdz_pkg::BYTE_ZERO);
        end
        else if (take && op_decrement_skip_if_zero)
        begin
          s_nxt.mem_we = 1'b1;
          s_nxt.wdata  = dec;
          if (dec == sbdz_pkg::BYTE_ZERO)
          begin
            s_nxt.skip = 1'b1;
            s_nxt.busy = 1'b1;
            s_nxt.st   = sbdz_pkg::st_dummy;
          end
          else
          begin
            // nonzero: the next opcode may follow at once
            s_nxt.st = sbdz_pkg::st_idle;
          end
        end
      end
      sbdz_pkg::st_dummy:
      begin
        // the skipped opcode is in fetch: any offer now is dropped
        s_nxt.st = sbdz_pkg::st_idle;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_r         <= '0;
      s_r.st      <= sbdz_pkg::st_idle;
      s_r.wdata   <= sbdz_pkg::DATA_RST;
      s_r.c       <= sbdz_pkg::FLAG_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign mem_we                    = s_r.mem_we;
  assign mem_wdata                 = s_r.wdata;
  assign flag_we                   = s_r.flag_we;
  assign carry_flag                = s_r.c;
  assign zero_flag                 = s_r.z;
  assign half_carry_flag           = s_r.half_c;
  assign arith_range_exceeded_flag = s_r.range_exc;
  assign signed_borrow_result_flag = s_r.sgn_b;
  assign chained_zero_flag         = s_r.chain_z;
  assign skip_next                 = s_r.skip;
  assign busy                      = s_r.busy;

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  logic sb_go;
  logic dz_go;
  assign sb_go = take && op_subtract_borrow_to_memory;
  assign dz_go = take && !op_subtract_borrow_to_memory
                 && op_decrement_skip_if_zero;

  sub_data_a: assert property (
    sb_go |=> mem_we && mem_wdata == 8'($past(acc_in) - $past(mem_rdata)
                                        - {7'h00, ~$past(carry_in)}))
    else $error("subtract result written wrong");

  borrow_clear_a: assert property (
    sb_go && ({1'b0, acc_in} < {1'b0, mem_rdata} + {8'h00, ~carry_in})
    |=> flag_we && !carry_flag)
    else $error("carry not cleared on borrow");

  no_borrow_set_a: assert property (
    sb_go && ({1'b0, acc_in} >= {1'b0, mem_rdata} + {8'h00, ~carry_in})
    |=> flag_we && carry_flag)
    else $error("carry not set without borrow");

  zero_flags_a: assert property (
    sb_go |=> zero_flag == (mem_wdata == 8'h00)
              && chained_zero_flag == (zero_flag && $past(chained_zero_in)))
    else $error("zero or chained zero flag wrong");

  dec_write_a: assert property (
    dz_go |=> mem_we && !flag_we && mem_wdata == 8'($past(mem_rdata) - 8'h01))
    else $error("decrement result wrong or flags touched");

  skip_dummy_a: assert property (
    dz_go && mem_rdata == 8'h01 |=> skip_next && busy ##1 !busy && !skip_next)
    else $error("skip or single dummy cycle missing");

  no_skip_a: assert property (
    dz_go && mem_rdata != 8'h01 |=> !skip_next && !busy)
    else $error("skip taken on nonzero result");

  wrap_a: assert property (
    dz_go && mem_rdata == 8'h00 |=> mem_wdata == 8'hff && !skip_next)
    else $error("zero byte did not wrap to ff");

  half_carry_a: assert property (
    sb_go |=> half_carry_flag == ({1'b0, $past(acc_in[3:0])}
              >= {1'b0, $past(mem_rdata[3:0])} + {4'h0, ~$past(carry_in)}))
    else $error("half carry flag wrong");

  range_flag_a: assert property (
    sb_go |=> arith_range_exceeded_flag
              == (($past(acc_in[7]) != $past(mem_rdata[7]))
                  && (mem_wdata[7] != $past(acc_in[7]))))
    else $error("overflow flag wrong");

  sign_flag_a: assert property (
    sb_go |=> signed_borrow_result_flag
              == ($signed({$past(acc_in[7]), $past(acc_in)})
                  < $signed({$past(mem_rdata[7]), $past(mem_rdata)})
                    + $signed({8'h00, ~$past(carry_in)})))
    else $error("signed borrow flag wrong");

  dummy_drop_a: assert property (
    busy && op_valid |=> !mem_we && !flag_we)
    else $error("opcode taken in dummy cycle");

  sub_borrow_c:  cover property (sb_go ##1 !carry_flag);
  dec_skip_c:    cover property (dz_go ##1 skip_next ##1 !busy);
  dec_wrap_c:    cover property (dz_go && mem_rdata == 8'h00);
  busy_drop_c:   cover property (busy && op_valid);

endmodule // sub_borrow_decrement_skip_exec

/* bench/data_mem_model.sv */
// byte store behind the decoder; the address is registered with the op
// so the late write lands on the byte that was read
module data_mem_model
(
  // clock
  input  wire logic       mclk,
  // access
  input  wire logic [1:0] addr,
  input  wire logic       we,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem_r [4];
  logic [1:0] addr_r;
  // forward a pending write, else back-to-back ops read a stale byte
  assign rdata = (we && addr_r == addr) ? wdata : mem_r[addr];
  always @(posedge mclk)
  begin
    addr_r <= addr;
    if (we)
      mem_r[addr_r] <= wdata;
  end
endmodule // data_mem_model

/* bench/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       mclk = 1'b0;
  logic       arst_n = 1'b0;
  logic       op_valid = 1'b0;
  logic       sel_sub = 1'b0;
  logic       sel_dec = 1'b0;
  logic       carry = 1'b0;
  logic       chain_in = 1'b0;
  logic [7:0] acc = 8'h00;
  logic [1:0] addr = 2'h0;
  logic [7:0] rdata, wdata;
  logic       mem_we, flag_we, cf, zf, hf, of, sf, czf, skip, busy;
  int         err_count = 0;
  int         n_compared = 0;

  always #5 mclk = ~mclk;

  data_mem_model mem (.mclk(mclk), .addr(addr), .we(mem_we),
    .wdata(wdata), .rdata(rdata));

  sub_borrow_decrement_skip_exec dut (.mclk(mclk), .arst_n(arst_n),
    .op_valid(op_valid), .op_subtract_borrow_to_memory(sel_sub),
    .op_decrement_skip_if_zero(sel_dec), .acc_in(acc),
    .mem_rdata(rdata), .carry_in(carry), .chained_zero_in(chain_in),
    .mem_we(mem_we), .mem_wdata(wdata), .flag_we(flag_we),
    .carry_flag(cf), .zero_flag(zf), .half_carry_flag(hf),
    .arith_range_exceeded_flag(of), .signed_borrow_result_flag(sf),
    .chained_zero_flag(czf), .skip_next(skip), .busy(busy));

  task automatic check(input string what, input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // preload the byte, offer the op for exactly one edge
  task automatic issue(input logic s, d, input logic [1:0] a,
                       input logic [7:0] v);
    mem.mem_r[a] = v;
    addr = a;
    sel_sub = s;
    sel_dec = d;
    op_valid = 1'b1;
    @(negedge mclk);
    op_valid = 1'b0;
  endtask

  task automatic t_sub(input logic [7:0] a, m, input logic c, z_in);
    logic [8:0] full;
    logic [4:0] low;
    logic [7:0] r;
    logic       ovf;
    logic [7:0] fl;
    full = {1'b0, a} - {1'b0, m} - {8'h00, ~c};
    low = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, ~c};
    r = full[7:0];
    ovf = (a[7] != m[7]) && (r[7] != a[7]);
    fl = {3'h0, r == 0, ~low[4], ovf, r[7] ^ ovf, z_in & (r == 0)};
    acc = a;
    carry = c;
    chain_in = z_in;
    issue(1'b1, 1'b0, 2'h1, m);
    check("sub wdata", wdata, r);
    check("sub strobes", {6'h0, mem_we, flag_we}, 8'h03);
    check("carry", {7'h0, cf}, {7'h0, ~full[8]});
    check("flags", {3'h0, zf, hf, of, sf, czf}, fl);
    @(negedge mclk);
    check("sub stored", mem.mem_r[1], r);
  endtask

  task automatic t_dec(input logic [7:0] m);
    logic [7:0] r;
    logic       z;
    r = m - 8'h01;
    z = (r == 8'h00);
    issue(1'b0, 1'b1, 2'h2, m);
    check("dec wdata", wdata, r);
    check("dec strobes", {6'h0, mem_we, flag_we}, 8'h02);
    check("skip", {6'h0, skip, busy}, {6'h0, z, z});
    // offered in the dummy cycle: must be dropped after a skip
    sel_sub = 1'b1;
    sel_dec = 1'b0;
    op_valid = 1'b1;
    @(negedge mclk);
    op_valid = 1'b0;
    check("dec stored", mem.mem_r[2], r);
    if (z)
      check("dummy", {4'h0, skip, mem_we, flag_we, busy}, 8'h00);
    else
      check("next", {4'h0, skip, mem_we, flag_we, busy}, 8'h06);
    @(negedge mclk);
  endtask

  initial
  begin
    repeat (20) @(negedge mclk);
    arst_n = 1'b1;
    @(negedge mclk);
    t_sub(8'h50, 8'h30, 1'b1, 1'b1);
    t_sub(8'h30, 8'h50, 1'b1, 1'b0);
    t_sub(8'h40, 8'h3f, 1'b0, 1'b1);
    t_sub(8'h80, 8'h01, 1'b1, 1'b1);
    t_sub(8'h7f, 8'hff, 1'b0, 1'b0);
    t_dec(8'h05);
    t_dec(8'h01);
    t_dec(8'h00);
    print_verdict();
  end

  initial
  begin
    #100000;
    err_count++;
    print_verdict();
  end
endmodule // tb_top
